//--- sxrm_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxrm_cfg.svh"
module sxrm_chk (
    input wire logic                          core_clk,
    input wire logic                          reset_n,
    input wire logic                          sel_n,
    input wire logic                          sdio_in,
    input wire logic                          sdio_out,
    input wire logic                          sdio_oe,
    input wire logic [`SXRM_PROG_COUNT*8-1:0] prog_ch1,
    input wire logic [`SXRM_PROG_COUNT*8-1:0] prog_ch2,
    input wire logic                          lsb_first
);
    logic [7:0] bits_q, bits_d;
    logic       idle_q, idle_d, rw_q, rw_d;
    // Bits of the current frame, held after it ends; rw_q is its read flag
    always_comb begin
        idle_d = sel_n;
        bits_d = bits_q;
        rw_d   = rw_q;
        if (!sel_n) begin
            bits_d = idle_q ? 8'h01 : bits_q + {7'h00, bits_q != 8'hFF};
            if (bits_d == (lsb_first ? 8'h10 : 8'h01)) rw_d = sdio_in;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bits_q <= 8'h00;
            idle_q <= 1'b1;
            rw_q   <= 1'b0;
        end else begin
            bits_q <= bits_d;
            idle_q <= idle_d;
            rw_q   <= rw_d;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_RST_VAL:
    assert property ($rose(reset_n) |-> !lsb_first && prog_ch1 == '0 && prog_ch2 == '0)
        else $error("bad reset outputs");
    AST_OE_FRAME:
    assert property (sdio_oe |-> !sel_n && rw_q && bits_q >= 8'h10) else $error("stray drive");
    AST_OE_RISE:
    assert property ($rose(sdio_oe) |-> bits_q == 8'h10) else $error("drive start off");
    AST_OE_HOLD:
    assert property (sdio_oe |=> sdio_oe || sel_n) else $error("drive dropped");
    AST_RD_DRIVE:
    assert property (!sel_n && rw_q && bits_q inside {[8'h10:8'h17]} |-> sdio_oe)
        else $error("no read drive");
    AST_PROG_FRAME:
    assert property (!$stable(prog_ch1) || !$stable(prog_ch2) |-> bits_q >= 8'h18)
        else $error("active copy changed early");
    AST_PROG_ONCE:
    assert property (!$stable(prog_ch1) |=> $stable(prog_ch1) [*8]) else $error("staggered copy");
    AST_LSB_FRAME:
    assert property (!$stable(lsb_first) |-> bits_q >= 8'h18) else $error("order changed early");
endmodule // sxrm_chk
bind sxrm_regmap sxrm_chk i_sxrm_chk (
    .core_clk(core_clk), .reset_n(reset_n), .sel_n(sel_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .prog_ch1(prog_ch1), .prog_ch2(prog_ch2),
    .lsb_first(lsb_first)
);
`default_nettype wire

//--- sxrm_cfg.svh
`ifndef SXRM_CFG_SVH
`define SXRM_CFG_SVH
`define SXRM_ADDR_PORT_CFG   8'h00
`define SXRM_ADDR_IDENTITY   8'h01
`define SXRM_ADDR_GRADE      8'h02
`define SXRM_ADDR_CHAN_SEL   8'h05
`define SXRM_ADDR_COMMIT     8'hFF
`define SXRM_PROG_FIRST      8'h08
`define SXRM_PROG_LAST       8'h38
`define SXRM_PROG_COUNT      49
`define SXRM_PORT_CFG_RST    8'h18
`define SXRM_CHAN_SEL_RST    8'h03
`define SXRM_CHAN_SEL_MASK   8'h03
`define SXRM_COMMIT_MASK     8'h01
`define SXRM_PROG_RST        8'h00
// Identity and grade codes are arbitrary neutral values
`define SXRM_IDENTITY_VAL    8'h5C
`define SXRM_GRADE_VAL       8'h20
`define SXRM_BIT_LSB_FIRST   6
`define SXRM_BIT_LSB_FIRST_M 1
`define SXRM_BIT_SOFT_RST    5
`define SXRM_BIT_SOFT_RST_M  2
`define SXRM_INSTR_BITS      16
`define SXRM_WORD_BITS       8
`endif

//--- sxrm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sxrm_host_model (
    input  wire logic core_clk,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    output var  logic sel_n,
    output wire logic sdio_in
);
    logic lsb, drv_on, drv_bit, noise_q;
    initial begin
        sel_n   = 1'b1;
        lsb     = 1'b0;
        drv_on  = 1'b0;
        drv_bit = 1'b0;
        noise_q = 1'b0;
    end
    always @(posedge core_clk) noise_q <= ~noise_q;
    // No pull on the shared line: an undriven line toggles
    assign sdio_in = sdio_oe ? sdio_out : (drv_on ? drv_bit : noise_q);
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [15:0] ins;
        ins  = {rd, 2'h0, a};
        rdat = 8'h00;
        for (int k = 0; k < 16; k++) begin
            @(posedge core_clk);
            sel_n   <= 1'b0;
            drv_on  <= 1'b1;
            drv_bit <= ins[lsb ? k : 15 - k];
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            drv_bit <= wd[lsb ? k : 7 - k];
            if (rd) begin
                drv_on <= 1'b0;
                @(negedge core_clk);
                rdat[lsb ? k : 7 - k] = sdio_in;
            end
        end
        @(posedge core_clk);
        sel_n  <= 1'b1;
        drv_on <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule // sxrm_host_model
`default_nettype wire

//--- sxrm_pkg.sv
`default_nettype none
package sxrm_pkg;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } sxrm_wr_t;
    typedef enum logic [2:0] {
        SXRM_INSTR = 3'b001,
        SXRM_WDATA = 3'b010,
        SXRM_RDATA = 3'b100
    } sxrm_state_t;
endpackage
`default_nettype wire

//--- sxrm_prog_cell.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxrm_cfg.svh"
// One shadowed byte: holding copy plus active copy
module sxrm_prog_cell (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       soft_rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       commit,
    output logic      [7:0] hold,
    output logic      [7:0] active
);
    logic [7:0] hold_q;
    logic [7:0] hold_d;
    logic [7:0] act_q;
    logic [7:0] act_d;
    always_comb begin
        hold_d = hold_q;
        act_d  = act_q;
        if (soft_rst) begin
            hold_d = `SXRM_PROG_RST;
            act_d  = `SXRM_PROG_RST;
        end else begin
            if (wr_en) begin
                hold_d = wr_data;
            end
            if (commit) begin
                act_d = hold_q;
            end
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= `SXRM_PROG_RST;
            act_q  <= `SXRM_PROG_RST;
        end else begin
            hold_q <= hold_d;
            act_q  <= act_d;
        end
    end
    assign hold   = hold_q;
    assign active = act_q;
endmodule // sxrm_prog_cell
`default_nettype wire

//--- sxrm_regmap.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxrm_cfg.svh"
// Operation
// - Config, index/commit, and program address groups
// - Reset loads documented default values
// - Program writes land in holding copies
// - Commit copies all at once, self-clears
// - Select bits steer channel-local copies
// - Both selected: writes reach both copies
// - Both selected: read returns channel one
// - Global registers ignore channel select
// - 16-bit instruction then 8-bit data words
// - MSB first default, LSB first selectable
module sxrm_regmap (
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    input  wire logic                     sel_n,
    input  wire logic                     sdio_in,
    output logic                          sdio_out,
    output logic                          sdio_oe,
    output logic [`SXRM_PROG_COUNT*8-1:0] prog_ch1,
    output logic [`SXRM_PROG_COUNT*8-1:0] prog_ch2,
    output logic                          lsb_first
);
    import sxrm_pkg::*;
    sxrm_state_t  st_q, st_d;
    logic [15:0]  sh_q, sh_d;
    logic [4:0]   cnt_q, cnt_d;
    logic         rd_q, rd_d;
    logic [12:0]  addr_q, addr_d;
    logic [7:0]   out_q, out_d;
    logic [7:0]   cfg_q, cfg_d;
    logic [7:0]   csel_q, csel_d;
    logic         commit_q, commit_d;
    sxrm_wr_t     wr;
    logic [7:0]   rdata;
    logic [`SXRM_PROG_COUNT*8-1:0] hold1, hold2;
    logic         soft_rst;
    logic [7:0]   pidx;
    logic         in_prog;
    logic [7:0]   wbyte;
    logic         lsbf;

    assign lsbf      = cfg_q[`SXRM_BIT_LSB_FIRST];
    assign lsb_first = lsbf;
    assign soft_rst  = cfg_q[`SXRM_BIT_SOFT_RST];
    assign pidx      = wr.addr - `SXRM_PROG_FIRST;
    assign in_prog   = (wr.addr >= `SXRM_PROG_FIRST) && (wr.addr <= `SXRM_PROG_LAST);

    // Serial framing: 16-bit instruction, then streamed bytes
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        addr_d = addr_q;
        out_d  = out_q;
        wr     = '0;
        wbyte  = {sh_q[6:0], sdio_in};
        if (sel_n) begin
            st_d  = SXRM_INSTR;
            cnt_d = 5'd0;
        end else begin
            case (st_q)
                SXRM_INSTR: begin
                    sh_d  = {sh_q[14:0], sdio_in};
                    cnt_d = cnt_q + 5'd1;
                    if (cnt_q == 5'(`SXRM_INSTR_BITS - 1)) begin
                        cnt_d = 5'd0;
                        if (lsbf) begin
                            rd_d   = sdio_in;
                            addr_d = {sh_q[2], sh_q[3], sh_q[4], sh_q[5], sh_q[6], sh_q[7],
                                      sh_q[8], sh_q[9], sh_q[10], sh_q[11], sh_q[12],
                                      sh_q[13], sh_q[14]};
                        end else begin
                            rd_d   = sh_q[14];
                            addr_d = {sh_q[11:0], sdio_in};
                        end
                        st_d = (lsbf ? sdio_in : sh_q[14]) ? SXRM_RDATA : SXRM_WDATA;
                        out_d = rdata;
                    end
                end
                SXRM_WDATA: begin
                    sh_d  = {sh_q[14:0], sdio_in};
                    cnt_d = cnt_q + 5'd1;
                    if (cnt_q == 5'(`SXRM_WORD_BITS - 1)) begin
                        cnt_d   = 5'd0;
                        wr.wr   = 1'b1;
                        wr.addr = addr_q[7:0];
                        wr.data = lsbf ? {wbyte[0], wbyte[1], wbyte[2], wbyte[3],
                                          wbyte[4], wbyte[5], wbyte[6], wbyte[7]}
                                       : wbyte;
                        addr_d  = lsbf ? addr_q + 13'd1 : addr_q - 13'd1;
                    end
                end
                SXRM_RDATA: begin
                    out_d = lsbf ? {1'b0, out_q[7:1]} : {out_q[6:0], 1'b0};
                    cnt_d = cnt_q + 5'd1;
                    if (cnt_q == 5'(`SXRM_WORD_BITS - 1)) begin
                        cnt_d  = 5'd0;
                        addr_d = lsbf ? addr_q + 13'd1 : addr_q - 13'd1;
                        out_d  = rdata;
                    end
                end
                default: st_d = SXRM_INSTR;
            endcase
        end
    end

    // Read mux addressed by the current frame address
    always_comb begin
        logic [7:0] ri;
        ri    = addr_q[7:0] - `SXRM_PROG_FIRST;
        rdata = 8'h00;
        if (rd_d && st_d != SXRM_INSTR || st_q == SXRM_RDATA) begin
            ri = (st_q == SXRM_RDATA ? (lsbf ? addr_q[7:0] + 8'd1 : addr_q[7:0] - 8'd1)
                                     : addr_d[7:0]) - `SXRM_PROG_FIRST;
        end
        case (ri + `SXRM_PROG_FIRST)
            `SXRM_ADDR_PORT_CFG: rdata = cfg_q;
            `SXRM_ADDR_IDENTITY: rdata = `SXRM_IDENTITY_VAL;
            `SXRM_ADDR_GRADE:    rdata = `SXRM_GRADE_VAL;
            `SXRM_ADDR_CHAN_SEL: rdata = csel_q;
            `SXRM_ADDR_COMMIT:   rdata = {7'd0, commit_q};
            default: begin
                if (ri <= (`SXRM_PROG_LAST - `SXRM_PROG_FIRST)) begin
                    // Channel one wins when both are selected
                    rdata = (csel_q[0] || !csel_q[1]) ? hold1[ri*8 +: 8]
                                                     : hold2[ri*8 +: 8];
                end
            end
        endcase
    end

    // Register writes
    always_comb begin
        cfg_d    = cfg_q;
        csel_d   = csel_q;
        commit_d = 1'b0;
        if (soft_rst) begin
            cfg_d  = `SXRM_PORT_CFG_RST;
            csel_d = `SXRM_CHAN_SEL_RST;
        end else if (wr.wr) begin
            case (wr.addr)
                `SXRM_ADDR_PORT_CFG: begin
                    // Either nibble's copy of a control sets it
                    cfg_d = `SXRM_PORT_CFG_RST;
                    cfg_d[`SXRM_BIT_LSB_FIRST]   = wr.data[`SXRM_BIT_LSB_FIRST]
                                                 | wr.data[`SXRM_BIT_LSB_FIRST_M];
                    cfg_d[`SXRM_BIT_LSB_FIRST_M] = cfg_d[`SXRM_BIT_LSB_FIRST];
                    cfg_d[`SXRM_BIT_SOFT_RST]    = wr.data[`SXRM_BIT_SOFT_RST]
                                                 | wr.data[`SXRM_BIT_SOFT_RST_M];
                    cfg_d[`SXRM_BIT_SOFT_RST_M]  = cfg_d[`SXRM_BIT_SOFT_RST];
                end
                `SXRM_ADDR_CHAN_SEL: csel_d = wr.data & `SXRM_CHAN_SEL_MASK;
                `SXRM_ADDR_COMMIT:   commit_d = wr.data[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q     <= SXRM_INSTR;
            sh_q     <= 16'h0000;
            cnt_q    <= 5'd0;
            rd_q     <= 1'b0;
            addr_q   <= 13'h0000;
            out_q    <= 8'h00;
            cfg_q    <= `SXRM_PORT_CFG_RST;
            csel_q   <= `SXRM_CHAN_SEL_RST;
            commit_q <= 1'b0;
        end else begin
            st_q     <= st_d;
            sh_q     <= sh_d;
            cnt_q    <= cnt_d;
            rd_q     <= rd_d;
            addr_q   <= addr_d;
            out_q    <= out_d;
            cfg_q    <= cfg_d;
            csel_q   <= csel_d;
            commit_q <= commit_d;
        end
    end

    assign sdio_oe  = (st_q == SXRM_RDATA) && !sel_n;
    assign sdio_out = lsbf ? out_q[0] : out_q[7];

    // Program registers held per channel; select bits steer writes
    genvar g;
    generate
        for (g = 0; g < `SXRM_PROG_COUNT; g++) begin : g_prog
            logic hit;
            assign hit = wr.wr && in_prog && (pidx == 8'(g));
            sxrm_prog_cell u_ch1 (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .soft_rst (soft_rst),
                .wr_en    (hit && csel_q[0]),
                .wr_data  (wr.data),
                .commit   (commit_q),
                .hold     (hold1[g*8 +: 8]),
                .active   (prog_ch1[g*8 +: 8])
            );
            sxrm_prog_cell u_ch2 (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .soft_rst (soft_rst),
                .wr_en    (hit && csel_q[1]),
                .wr_data  (wr.data),
                .commit   (commit_q),
                .hold     (hold2[g*8 +: 8]),
                .active   (prog_ch2[g*8 +: 8])
            );
        end
    endgenerate
endmodule // sxrm_regmap
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sxrm_cfg.svh"
module tb_top;
    localparam int NB = `SXRM_PROG_COUNT;
    localparam int W  = NB * 8;
    logic            core_clk, reset_n, sel_n, sdio_in, sdio_out, sdio_oe, lsb_first;
    logic [NB*8-1:0] prog_ch1, prog_ch2, exp1, exp2;
    logic [7:0]      rd, v;
    logic [1:0]      s;
    int              errors = 0, cmp_count = 0, cyc = 0, n;
    logic [7:0]      ra[6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'hFF, 8'h40};
    logic [7:0]      re[6] = '{8'h18, `SXRM_IDENTITY_VAL, `SXRM_GRADE_VAL, 8'h03, 8'h00, 8'h00};
    sxrm_regmap i_sxrm_regmap (.core_clk(core_clk), .reset_n(reset_n), .sel_n(sel_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .prog_ch1(prog_ch1),
        .prog_ch2(prog_ch2), .lsb_first(lsb_first));
    sxrm_host_model i_host (.core_clk(core_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sel_n(sel_n), .sdio_in(sdio_in));
    function automatic logic [NB*8-1:0] put(input logic [NB*8-1:0] m, input int i,
                                            input logic [7:0] b);
        m[i*8 +: 8] = b;
        return m;
    endfunction
    task automatic check(input logic [NB*8-1:0] got, input logic [NB*8-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, {5'h00, a}, d, rd);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(1'b1, {5'h00, a}, 8'h00, rd);
        check(W'(rd), W'(e));
    endtask
    task automatic test_done();
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        reset_n = 1'b0;
        exp1    = '0;
        exp2    = '0;
        void'($urandom(98));
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (ra[j]) rchk(ra[j], re[j]);
        wr(8'h01, 8'($urandom));
        rchk(8'h01, `SXRM_IDENTITY_VAL);
        for (int it = 0; it < 12; it++) begin
            s = 2'(it % 3 + 1);
            n = (it == 0) ? 0 : (it == 1) ? NB - 1 : $urandom_range(NB - 1);
            if (n == 11) n = 12;
            v = 8'($urandom);
            wr(8'h05, {6'h00, s});
            wr(8'(8 + n), v);
            check(prog_ch1, exp1);
            check(prog_ch2, exp2);
            if (s[0]) exp1 = put(exp1, n, v);
            if (s[1]) exp2 = put(exp2, n, v);
            wr(8'hFF, 8'h01);
            check(prog_ch1, exp1);
            check(prog_ch2, exp2);
            rchk(8'(8 + n), (s == 2'h2) ? exp2[n*8 +: 8] : exp1[n*8 +: 8]);
            rchk(8'hFF, 8'h00);
            rchk(8'h02, `SXRM_GRADE_VAL);
        end
        wr(8'h05, 8'h01);
        wr(8'h09, 8'hA5);
        wr(8'h05, 8'h02);
        wr(8'h09, 8'h5A);
        rchk(8'h09, 8'h5A);
        wr(8'h05, 8'h03);
        rchk(8'h09, 8'hA5);
        wr(8'h00, 8'h1A);
        check(W'(lsb_first), W'(1'b1));
        i_host.lsb = 1'b1;
        rchk(8'h00, 8'h5A);
        rchk(8'h01, `SXRM_IDENTITY_VAL);
        wr(8'h00, 8'h1C);
        i_host.lsb = 1'b0;
        check(W'(lsb_first), W'(1'b0));
        check(prog_ch1 | prog_ch2, '0);
        rchk(8'h00, `SXRM_PORT_CFG_RST);
        rchk(8'h05, `SXRM_CHAN_SEL_RST);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
